//--- hw/scss_divider.v
// Divides a clock enable stream by 1, 2, 4 or 8.
// Assumes the source tick and code are synchronous to the system clock.
`timescale 1ns/10ps
module scss_divider (
	input  wire       clk_in,
	input  wire       arst_n_in,
	input  wire       tick_in,
	input  wire [1:0] code_in,
	output reg        tick_out
);
	reg [2:0] cnt_q;
	reg [2:0] mask;

	always @* begin
		case (code_in)
			2'b00: mask = 3'h0;
			2'b01: mask = 3'h1;
			2'b10: mask = 3'h3;
			default: mask = 3'h7;
		endcase
	end

	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q    <= 3'h0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (tick_in) begin
				if ((cnt_q & mask) == mask) begin
					cnt_q    <= 3'h0;
					tick_out <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 3'h1;
				end
			end
		end
	end
endmodule // scss_divider

//--- hw/scss_slow_osc.v
// Models the 4 kHz low-frequency oscillator as a free tick.
// Assumes CLK_SYS runs at the rate given in the defs header.
`timescale 1ns/10ps
`include "scss_defs.vh"
module scss_slow_osc #(
	parameter integer CYCLES = `SCSS_SLOW_CYCLES
) (
	input  wire clk_in,
	input  wire arst_n_in,
	output reg  tick_out
);
	reg [31:0] cnt_q;

	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q    <= 32'h0000_0000;
			tick_out <= 1'b0;
		end else if (cnt_q == CYCLES - 1) begin
			cnt_q    <= 32'h0000_0000;
			tick_out <= 1'b1;
		end else begin
			cnt_q    <= cnt_q + 32'h0000_0001;
			tick_out <= 1'b0;
		end
	end
endmodule // scss_slow_osc

//--- hw/scss_top.v
// System clock source select with Avalon-MM register slave.
// Assumes the oscillators are modelled as tick inputs synchronous to CLK_SYS_IN.
//
// Function
// - Two sources, internal or crystal, software chosen
// - Divider code gives divide by 1,2,4,8
// - Source bit 0 internal, 1 crystal
// - Band field configures crystal, valid with pads
// - Seven bit trim adjusts internal oscillator
// - Detect enable active low; status read only
// - Threshold field selects detect level
// - Reset enable active low
// - Clock output enable drives clock on pin
// - Separate 4 kHz oscillator for slow tick
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/10ps
`include "scss_defs.vh"
module scss_top #(
	parameter integer SLOW_CYCLES = `SCSS_SLOW_CYCLES
) (
	input  wire        CLK_SYS_IN,
	input  wire        ARST_N_IN,
	input  wire [9:0]  AVS_ADDRESS_IN,
	input  wire        AVS_READ_IN,
	input  wire        AVS_WRITE_IN,
	input  wire [31:0] AVS_WRITEDATA_IN,
	input  wire [3:0]  AVS_BYTEENABLE_IN,
	output reg  [31:0] AVS_READDATA_OUT,
	output wire        AVS_WAITREQUEST_OUT,
	input  wire        INT_OSC_TICK_IN,
	input  wire        XTAL_TICK_IN,
	input  wire        UNDERVOLTAGE_DETECT_IN,
	output wire        SYSTEM_CLOCK_TICK_OUT,
	output reg         PORT3_PIN4_OUT,
	output wire        PORT3_PIN4_OE_N_OUT,
	output wire        CRYSTAL_PAD_ENABLE_OUT,
	output wire [1:0]  CRYSTAL_BAND_SELECT_OUT,
	output wire [6:0]  INTERNAL_TRIM_OUT,
	output wire        UNDERVOLTAGE_DETECT_DISABLE_OUT,
	output wire [1:0]  UNDERVOLTAGE_THRESHOLD_OUT,
	output wire        UNDERVOLTAGE_RESET_DISABLE_OUT,
	output wire        SLOW_TICK_OUT,
	output wire        IRQ_OUT
);
	// ==========================================================
	// Registers
	reg  [7:0]  oscctl_q;
	reg  [6:0]  syscon_q;
	reg  [1:0]  xrange_q;
	reg  [6:0]  trim_q;
	reg  [1:0]  irq_stat_q;
	reg  [1:0]  irq_mask_q;
	reg  [1:0]  key_state_q;
	reg         lvd_sync_q;
	reg         lvd_flag_q;
	reg         ack_q;
	reg         sys_tick_q;
	wire [7:0]  index;
	wire        req;
	wire        wr_lane0;
	wire        rd_stat;
	wire        slow_tick;
	wire        src_tick;
	wire        div_tick;
	wire        lvd_rise;
	wire        key_open;
	reg  [7:0]  rd_byte;

	localparam [1:0] KEY_IDLE = 2'h0;
	localparam [1:0] KEY_HALF = 2'h1;
	localparam [1:0] KEY_OPEN = 2'h2;

	assign index    = AVS_ADDRESS_IN[9:2];
	assign req      = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;
	assign wr_lane0 = AVS_WRITE_IN & ack_q & AVS_BYTEENABLE_IN[0];
	assign rd_stat  = AVS_READ_IN & ack_q & (index == `SCSS_IDX_IRQ_STAT);
	assign key_open = (key_state_q == KEY_OPEN);

	// ==========================================================
	// Bus handshake: one wait state, answer on the second edge
	assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;

	always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	always @* begin
		case (index)
			`SCSS_IDX_OSCCTL:   rd_byte = oscctl_q;
			`SCSS_IDX_SYSCON:   rd_byte = {lvd_flag_q, syscon_q};
			`SCSS_IDX_XRANGE:   rd_byte = {6'h00, xrange_q};
			`SCSS_IDX_TRIM:     rd_byte = {1'b0, trim_q};
			`SCSS_IDX_IRQ_STAT: rd_byte = {6'h00, irq_stat_q};
			`SCSS_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_q};
			`SCSS_IDX_KEY:      rd_byte = {6'h00, key_state_q};
			default:            rd_byte = 8'h00;
		endcase
	end

	always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			AVS_READDATA_OUT <= 32'h0000_0000;
		end else if (AVS_READ_IN & ~ack_q) begin
			AVS_READDATA_OUT <= {24'h00_0000, rd_byte};
		end
	end

	// ==========================================================
	// Control registers
	always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			oscctl_q <= `SCSS_OSCCTL_RST;
			xrange_q <= 2'h0;
			trim_q   <= 7'h40;
			irq_mask_q <= 2'h0;
		end else if (wr_lane0) begin
			case (index)
				`SCSS_IDX_OSCCTL:   oscctl_q   <= AVS_WRITEDATA_IN[7:0];
				`SCSS_IDX_XRANGE:   xrange_q   <= AVS_WRITEDATA_IN[1:0];
				`SCSS_IDX_TRIM:     trim_q     <= AVS_WRITEDATA_IN[6:0];
				`SCSS_IDX_IRQ_MASK: irq_mask_q <= AVS_WRITEDATA_IN[1:0];
				default:            oscctl_q   <= oscctl_q;
			endcase
		end
	end

	// Key sequence: first byte, second byte, then one write is let through
	always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			key_state_q <= KEY_IDLE;
			syscon_q    <= 7'h00;
		end else if (wr_lane0) begin
			if (index == `SCSS_IDX_KEY) begin
				case (key_state_q)
					KEY_IDLE: key_state_q <= (AVS_WRITEDATA_IN[7:0] == `SCSS_KEY_FIRST)
						? KEY_HALF : KEY_IDLE;
					KEY_HALF: key_state_q <= (AVS_WRITEDATA_IN[7:0] == `SCSS_KEY_SECOND)
						? KEY_OPEN : KEY_IDLE;
					default:  key_state_q <= KEY_IDLE;
				endcase
			end else if (index == `SCSS_IDX_SYSCON) begin
				if (key_open) begin
					syscon_q <= AVS_WRITEDATA_IN[6:0];
				end
				key_state_q <= KEY_IDLE;
			end
		end
	end

	// ==========================================================
	// Undervoltage flag follows the comparator, gated by the active-low enable
	always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			lvd_sync_q <= 1'b0;
			lvd_flag_q <= 1'b0;
		end else begin
			lvd_sync_q <= UNDERVOLTAGE_DETECT_IN;
			lvd_flag_q <= lvd_sync_q & ~syscon_q[`SCSS_LVD_DIS_BIT];
		end
	end

	assign lvd_rise = lvd_sync_q & ~syscon_q[`SCSS_LVD_DIS_BIT] & ~lvd_flag_q;

	// ==========================================================
	// Interrupts: bit0 detect event, bit1 slow tick; read clears, set wins
	always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			irq_stat_q <= 2'h0;
		end else begin
			irq_stat_q <= (rd_stat ? 2'h0 : irq_stat_q) | {slow_tick, lvd_rise};
		end
	end

	assign IRQ_OUT = |(irq_stat_q & irq_mask_q);

	// ==========================================================
	// Clock path
	assign src_tick = oscctl_q[`SCSS_SEL_BIT] ? XTAL_TICK_IN : INT_OSC_TICK_IN;

	scss_divider u_div (
		.clk_in   (CLK_SYS_IN),
		.arst_n_in(ARST_N_IN),
		.tick_in  (src_tick),
		.code_in  (oscctl_q[1:0]),
		.tick_out (div_tick)
	);

	scss_slow_osc #(
		.CYCLES(SLOW_CYCLES)
	) u_slow (
		.clk_in   (CLK_SYS_IN),
		.arst_n_in(ARST_N_IN),
		.tick_out (slow_tick)
	);

	// Pin toggles on each divided tick so it carries a square system clock
	always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			sys_tick_q     <= 1'b0;
			PORT3_PIN4_OUT <= 1'b0;
		end else begin
			sys_tick_q <= div_tick;
			if (!syscon_q[`SCSS_CLKOUT_BIT]) begin
				PORT3_PIN4_OUT <= 1'b0;
			end else if (div_tick) begin
				PORT3_PIN4_OUT <= ~PORT3_PIN4_OUT;
			end
		end
	end

	assign SYSTEM_CLOCK_TICK_OUT           = sys_tick_q;
	assign PORT3_PIN4_OE_N_OUT             = ~syscon_q[`SCSS_CLKOUT_BIT];
	assign CRYSTAL_PAD_ENABLE_OUT          = oscctl_q[`SCSS_PAD_BIT];
	assign CRYSTAL_BAND_SELECT_OUT         = oscctl_q[`SCSS_PAD_BIT] ? xrange_q : 2'h0;
	assign INTERNAL_TRIM_OUT               = trim_q;
	assign UNDERVOLTAGE_DETECT_DISABLE_OUT = syscon_q[`SCSS_LVD_DIS_BIT];
	assign UNDERVOLTAGE_THRESHOLD_OUT      = syscon_q[5:4];
	assign UNDERVOLTAGE_RESET_DISABLE_OUT  = syscon_q[`SCSS_LVR_DIS_BIT];
	assign SLOW_TICK_OUT                   = slow_tick;
endmodule // scss_top

//--- inc/scss_defs.vh
// Constants for the system clock source select block.
// Assumes inclusion by the design files of this block only.
`ifndef SCSS_DEFS_VH
`define SCSS_DEFS_VH
// ==========================================================
// Register word indices (printed offsets are not word aligned, so byte = 4 * index)
`define SCSS_IDX_SYSCON      8'hAE
`define SCSS_IDX_XRANGE      8'hFA
`define SCSS_IDX_TRIM        8'hFB
`define SCSS_IDX_OSCCTL      8'h10
`define SCSS_IDX_IRQ_STAT    8'h11
`define SCSS_IDX_IRQ_MASK    8'h12
`define SCSS_IDX_KEY         8'h13
// ==========================================================
// Field positions
`define SCSS_DIV_LSB         0
`define SCSS_SEL_BIT         3
`define SCSS_PAD_BIT         5
`define SCSS_CLKOUT_BIT      2
`define SCSS_LVR_DIS_BIT     3
`define SCSS_THR_LSB         4
`define SCSS_LVD_DIS_BIT     6
`define SCSS_LVD_FLAG_BIT    7
// ==========================================================
// Reset values
`define SCSS_OSCCTL_RST      8'h00
`define SCSS_SYSCON_RST      8'h00
`define SCSS_XRANGE_RST      8'h00
`define SCSS_TRIM_RST        8'h40
// ==========================================================
// Key sequence guarding the system control register
`define SCSS_KEY_FIRST       8'hFF
`define SCSS_KEY_SECOND      8'h00
// ==========================================================
// Timing: 50 MHz system clock, 4 kHz slow tick
`define SCSS_CLK_HZ          50000000
`define SCSS_SLOW_HZ         4000
`define SCSS_SLOW_CYCLES     (`SCSS_CLK_HZ / `SCSS_SLOW_HZ)
`endif

//--- tb/scss_osc_model.sv
// Oscillator models that feed the two source tick inputs.
// Assumes one system clock; the crystal only runs with its pads on.
`timescale 1ns/10ps
module scss_osc_model (
	input  wire  clk_in,
	input  wire  arst_n_in,
	input  wire  pad_en_in,
	output logic int_tick_out,
	output logic xtal_tick_out
);
	logic [1:0] cnt_q;
	logic       ph_q;
	// ==========================================================
	// Internal source every 2nd clock, crystal every 3rd
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ph_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			ph_q <= !ph_q;
			cnt_q <= (cnt_q == 2'h2 || !pad_en_in) ? 2'h0 : cnt_q + 2'h1;
		end
	end
	assign int_tick_out = ph_q;
	assign xtal_tick_out = pad_en_in && cnt_q == 2'h2;
endmodule // scss_osc_model

//--- tb/scss_top_checker.sv
// Port assertions for the clock source select block.
// Assumes a bind onto scss_top with a slow tick of 8 clocks.
`timescale 1ns/10ps
module scss_top_checker #(
	parameter integer SLOW_CYCLES = 8
) (
	input wire       CLK_SYS_IN,
	input wire       ARST_N_IN,
	input wire       AVS_READ_IN,
	input wire       AVS_WRITE_IN,
	input wire       AVS_WAITREQUEST_OUT,
	input wire       INT_OSC_TICK_IN,
	input wire       XTAL_TICK_IN,
	input wire       SYSTEM_CLOCK_TICK_OUT,
	input wire       PORT3_PIN4_OUT,
	input wire       PORT3_PIN4_OE_N_OUT,
	input wire       CRYSTAL_PAD_ENABLE_OUT,
	input wire [1:0] CRYSTAL_BAND_SELECT_OUT,
	input wire [6:0] INTERNAL_TRIM_OUT,
	input wire       UNDERVOLTAGE_DETECT_DISABLE_OUT,
	input wire [1:0] UNDERVOLTAGE_THRESHOLD_OUT,
	input wire       UNDERVOLTAGE_RESET_DISABLE_OUT,
	input wire       SLOW_TICK_OUT
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!ARST_N_IN);
	sequence s_req; (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT; endsequence
	sequence s_gap; !SLOW_TICK_OUT [*7] ##1 SLOW_TICK_OUT; endsequence
	property p_ws; s_req |=> !AVS_WAITREQUEST_OUT; endproperty
	property p_idle; !(AVS_READ_IN || AVS_WRITE_IN) |-> !AVS_WAITREQUEST_OUT; endproperty
	property p_band; !CRYSTAL_PAD_ENABLE_OUT |-> CRYSTAL_BAND_SELECT_OUT == 2'h0; endproperty
	property p_oe; PORT3_PIN4_OE_N_OUT [*2] |-> !PORT3_PIN4_OUT; endproperty
	property p_src; SYSTEM_CLOCK_TICK_OUT |-> $past(INT_OSC_TICK_IN || XTAL_TICK_IN, 2); endproperty
	property p_slow; SLOW_TICK_OUT |=> s_gap; endproperty
	property p_trim; !AVS_WRITE_IN |=> $stable(INTERNAL_TRIM_OUT); endproperty
	property p_cfg; !AVS_WRITE_IN |=> $stable({UNDERVOLTAGE_DETECT_DISABLE_OUT,
		UNDERVOLTAGE_THRESHOLD_OUT, UNDERVOLTAGE_RESET_DISABLE_OUT, PORT3_PIN4_OE_N_OUT}); endproperty
	a_ws: assert property (p_ws) else $error("wait state not one cycle");
	a_idle: assert property (p_idle) else $error("waitrequest while idle");
	a_band: assert property (p_band) else $error("band set with pads off");
	a_oe: assert property (p_oe) else $error("pin driven while off");
	a_src: assert property (p_src) else $error("tick without source");
	a_slow: assert property (p_slow) else $error("slow tick spacing");
	a_trim: assert property (p_trim) else $error("trim moved without write");
	a_cfg: assert property (p_cfg) else $error("control moved without write");
endmodule // scss_top_checker
bind scss_top scss_top_checker #(.SLOW_CYCLES(SLOW_CYCLES)) scss_top_checker_i (.*);

//--- tb/scss_top_tb.sv
// Self-checking bench for the clock source select block.
// Assumes the checker binds itself and the oscillator model feeds the ticks.
`timescale 1ns/10ps
module scss_top_tb;
	logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, uv = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [31:0] wd = 32'h0000_0000, rdat;
	logic        wq, it, xt, st, pin, oe_n, pad, ddis, rdis, irq;
	logic [1:0]  band, thr;
	logic [6:0]  trim;
	int          n_fail = 0, num_checks = 0, cyc = 0;
	always #10 clk = !clk;
	scss_top #(.SLOW_CYCLES(8)) scss_top_i (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n),
		.AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
		.AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wq),
		.INT_OSC_TICK_IN(it), .XTAL_TICK_IN(xt), .UNDERVOLTAGE_DETECT_IN(uv),
		.SYSTEM_CLOCK_TICK_OUT(st), .PORT3_PIN4_OUT(pin), .PORT3_PIN4_OE_N_OUT(oe_n),
		.CRYSTAL_PAD_ENABLE_OUT(pad), .CRYSTAL_BAND_SELECT_OUT(band),
		.INTERNAL_TRIM_OUT(trim), .UNDERVOLTAGE_DETECT_DISABLE_OUT(ddis),
		.UNDERVOLTAGE_THRESHOLD_OUT(thr), .UNDERVOLTAGE_RESET_DISABLE_OUT(rdis),
		.SLOW_TICK_OUT(), .IRQ_OUT(irq));
	scss_osc_model scss_osc_model_i (.clk_in(clk), .arst_n_in(rst_n), .pad_en_in(pad),
		.int_tick_out(it), .xtal_tick_out(xt));
	// ==========================================================
	// Bus and compare helpers
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		adr <= a;
		wd <= {24'h00_0000, d};
		rd <= !w;
		wr <= w;
		do @(posedge clk); while (wq !== 1'b0);
		q = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		@(negedge clk);
	endtask
	task automatic w(input logic [9:0] a, input logic [7:0] d);
		logic [7:0] x;
		bus(a, 1'b1, d, x);
	endtask
	task automatic rc(input logic [9:0] a, input logic [7:0] e, input string nm);
		logic [7:0] x;
		bus(a, 1'b0, 8'h00, x);
		chk(nm, e, x);
	endtask
	task automatic per(input logic [7:0] e, input string nm);
		int n;
		n = 0;
		repeat (2) do @(negedge clk); while (st !== 1'b1);
		do begin
			@(negedge clk);
			n++;
		end while (st !== 1'b1);
		chk(nm, e, n[7:0]);
	endtask
	task automatic unlock();
		w(10'h04C, 8'hFF);
		w(10'h04C, 8'h00);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		rc(10'h040, 8'h00, "osc ctl");
		rc(10'h3E8, 8'h00, "xrange");
		rc(10'h3EC, 8'h40, "trim");
		rc(10'h2B8, 8'h00, "sysctl");
		rc(10'h000, 8'h00, "unmapped");
	endtask
	task automatic t_clk();
		for (int c = 0; c < 4; c++) begin
			w(10'h040, 8'(c));
			per(8'(2 << c), "int period");
		end
		w(10'h3E8, 8'h02);
		chk("band off", 8'h00, 8'(band));
		w(10'h040, 8'h20);
		chk("band on", 8'h02, 8'(band));
		repeat (20) @(posedge clk);
		w(10'h040, 8'h2B);
		per(8'd24, "xtal period");
		w(10'h040, 8'h00);
		per(8'd2, "back period");
		w(10'h3EC, 8'h7F);
		chk("trim out", 8'h7F, 8'(trim));
	endtask
	task automatic t_sys();
		logic x;
		w(10'h2B8, 8'h4C);
		rc(10'h2B8, 8'h00, "no key");
		for (int t = 0; t < 4; t++) begin
			unlock();
			w(10'h2B8, 8'hCC | 8'(t << 4));
			rc(10'h2B8, 8'h4C | 8'(t << 4), "sysctl");
			chk("thr", 8'(t), 8'(thr));
		end
		chk("flags", 8'h03, {6'h00, ddis, rdis});
		chk("oe_n", 8'h00, 8'(oe_n));
		@(negedge clk);
		x = pin;
		repeat (2) @(negedge clk);
		chk("pin", 8'(!x), 8'(pin));
	endtask
	task automatic t_irq();
		logic [7:0] x;
		unlock();
		w(10'h2B8, 8'h3C);
		w(10'h048, 8'h00);
		@(posedge clk);
		uv <= 1'b1;
		repeat (2) @(posedge clk);
		rc(10'h2B8, 8'hBC, "flag");
		chk("irq masked", 8'h00, 8'(irq));
		w(10'h048, 8'h01);
		chk("irq", 8'h01, 8'(irq));
		bus(10'h044, 1'b0, 8'h00, x);
		chk("stat", 8'h01, x & 8'h01);
		@(negedge clk);
		chk("irq clear", 8'h00, 8'(irq));
		unlock();
		w(10'h2B8, 8'h7C);
		rc(10'h2B8, 8'h7C, "flag off");
		w(10'h048, 8'h02);
		repeat (9) @(negedge clk);
		chk("irq slow", 8'h01, 8'(irq));
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_clk();
		t_sys();
		t_irq();
		end_of_test();
	end
endmodule // scss_top_tb
